// ### dv/hidr_host_model.sv
// Host bus model: answers driven DMA requests with acknowledges
`timescale 1ns/1ps
`default_nettype none
module hidr_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic [7:0] drq_line_out,
  input  wire logic [7:0] drq_line_oe,
  output var  logic [7:0] dack_line_in
);
  logic [7:0] drq_seen;  // Requests driven and high
  logic [7:0] seen_reg;  // Requests seen at the previous edge
  logic [2:0] wait_cnt;  // Grant latency
  assign drq_seen = drq_line_out & drq_line_oe;
  // Grant the lowest request after a latency that restarts when requests change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg     <= 8'h00;
      wait_cnt     <= 3'h0;
      dack_line_in <= 8'h00;
    end else begin
      seen_reg <= drq_seen;
      if (drq_seen == 8'h00 || drq_seen != seen_reg) begin
        // Request gone or moved, so the acknowledge drops
        wait_cnt     <= 3'h0;
        dack_line_in <= 8'h00;
      end else if (wait_cnt >= (slow ? 3'h4 : 3'h1)) begin
        dack_line_in <= drq_seen & ~(drq_seen - 8'h01);
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule : hidr_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the host I/O decode and line routing block
`timescale 1ns/1ps
`default_nettype none
`include "hidr_map.svh"
module testbench;
  import hidr_pkg::*;
  localparam logic [9:0] BASE = 10'h340;  // Default window
  logic        clk = 1'b0;
  logic        rst_n;
  logic [9:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata;
  logic        io_wr, io_rd, io_hit, berr, ext_irq, board_irq;
  logic [4:0]  sw;
  logic [7:0]  irq_j, drq_out, drq_oe, dack;
  logic [5:0]  drq_j, dack_j;
  logic [15:0] irq_out, irq_oe, e;
  logic        mreq, sreq, mack, sack, slow;
  int          err_total = 0;
  int          checked = 0;
  int          legal[$] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};  // Usable levels

  always #25 clk = ~clk;

  hidr_top i_dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
    .base_address_switch_bank(sw), .interrupt_route_jumpers(irq_j),
    .dma_request_route_jumpers(drq_j), .dma_ack_route_jumpers(dack_j),
    .board_err_evt(berr), .ext_bus_irq(ext_irq), .board_irq(board_irq),
    .irq_line_out(irq_out), .irq_line_oe(irq_oe), .master_dma_req(mreq),
    .slave_dma_req(sreq), .drq_line_out(drq_out), .drq_line_oe(drq_oe),
    .dack_line_in(dack), .master_dma_ack(mack), .slave_dma_ack(sack));

  hidr_host_model i_host (.clk(clk), .rst_n(rst_n), .slow(slow), .drq_line_out(drq_out),
    .drq_line_oe(drq_oe), .dack_line_in(dack));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Wait edges, then let them settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One-cycle register write
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr    <= 1'b0;
  endtask : wr

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd   <= 1'b0;
    #1 chk(what, {8'h00, io_rdata}, {8'h00, exp});
  endtask : rd

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #(50 * 5000);
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [4:0] s;
    logic [9:0] b;
    void'($urandom(85584));
    {io_addr, io_wdata, io_wr, io_rd, berr, ext_irq, mreq, sreq, slow} = '0;
    sw = 5'h1a;
    irq_j = 8'hac;
    drq_j = 6'h1e;
    dack_j = 6'h1e;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk("irq_oe", irq_oe, 16'h0000);
    chk("drq_oe", {8'h00, drq_oe}, 16'h0000);
    rd(BASE + `HIDR_IDX_ROUTE, 8'hac, "route");
    rd(BASE + `HIDR_IDX_DMA, 8'h36, "dma");
    $display("test reset done");
    // Random switch settings, low page included
    for (int i = 0; i < 12; i++) begin
      s = (i < 2) ? 5'(i) : 5'($urandom_range(31, 8));
      b = {s, 5'h00};
      @(posedge clk) sw <= s;
      tick(2);
      @(posedge clk) io_addr <= b + 10'($urandom_range(31, 0));
      #1 chk("hit", {15'h0, io_hit}, {15'h0, s[4:3] != 2'h0});
      @(posedge clk) io_addr <= b ^ (10'h020 << $urandom_range(4, 0));
      #1 chk("miss", {15'h0, io_hit}, 16'h0000);
      rd(b + `HIDR_IDX_ROUTE, (s[4:3] != 2'h0) ? 8'hac : 8'h00, "win_rd");
      rd(b ^ 10'h200, 8'h00, "out_rd");
    end
    @(posedge clk) sw <= 5'h1a;
    tick(2);
    $display("test window done");
    // Every level on the external route
    wr(BASE + `HIDR_IDX_CTRL, 8'h02);
    @(posedge clk) ext_irq <= 1'b1;
    for (int l = 0; l < 16; l++) begin
      @(posedge clk) irq_j <= {4'(l), 4'hc};
      tick(3);
      e = (l inside {legal}) ? (16'h0001 << l) : 16'h0000;
      chk("ext_oe", irq_oe, e);
      chk("ext_out", irq_out, e);
    end
    wr(BASE + `HIDR_IDX_CTRL, 8'h00);
    tick(3);
    chk("dis_oe", irq_oe, 16'h0000);
    $display("test levels done");
    // Board status interrupt, clear and mask
    @(posedge clk) ext_irq <= 1'b0;
    irq_j <= 8'hac;
    wr(BASE + `HIDR_IDX_CLR, 8'h07);
    wr(BASE + `HIDR_IDX_IEN, 8'h01);
    wr(BASE + `HIDR_IDX_CTRL, 8'h01);
    @(posedge clk) berr <= 1'b1;
    @(posedge clk) berr <= 1'b0;
    tick(3);
    chk("birq", {15'h0, board_irq}, 16'h0001);
    chk("b_oe", irq_oe, 16'h1000);
    chk("b_out", irq_out, 16'h1000);
    rd(BASE + `HIDR_IDX_STAT, 8'h01, "stat");
    wr(BASE + `HIDR_IDX_CLR, 8'h01);
    tick(3);
    chk("birq_clr", {15'h0, board_irq}, 16'h0000);
    chk("b_oe_low", irq_oe, 16'h1000);
    chk("b_out_low", irq_out, 16'h0000);
    wr(BASE + `HIDR_IDX_IEN, 8'h02);
    @(posedge clk) ext_irq <= 1'b1;
    tick(3);
    chk("e_birq", {15'h0, board_irq}, 16'h0001);
    chk("e_out", irq_out, 16'h1000);
    chk("e_oe", irq_oe, 16'h1000);
    rd(BASE + `HIDR_IDX_STAT, 8'h02, "stat_e");
    wr(BASE + `HIDR_IDX_CLR, 8'h02);
    rd(BASE + `HIDR_IDX_STAT, 8'h02, "set_wins");
    wr(BASE + `HIDR_IDX_IEN, 8'h00);
    tick(1);
    chk("masked", {15'h0, board_irq}, 16'h0000);
    $display("test board irq done");
    // DMA channels with prompt and slow host
    @(posedge clk) ext_irq <= 1'b0;
    wr(BASE + `HIDR_IDX_CLR, 8'h07);
    wr(BASE + `HIDR_IDX_CTRL, 8'h0c);
    rd(BASE + `HIDR_IDX_CTRL, 8'h0c, "ctrl");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) slow <= 1'(j);
      mreq <= 1'b1;
      tick(2);
      chk("m_oe", {8'h00, drq_oe}, 16'h0048);
      chk("m_out", {8'h00, drq_out & drq_oe}, 16'h0040);
      for (int k = 0; k < 10 && mack !== 1'b1; k++) tick(1);
      chk("mack", {15'h0, mack}, 16'h0001);
      @(posedge clk) mreq <= 1'b0;
      sreq <= 1'b1;
      tick(2);
      for (int k = 0; k < 10 && sack !== 1'b1; k++) tick(1);
      chk("sack", {15'h0, sack}, 16'h0001);
      @(posedge clk) sreq <= 1'b0;
    end
    @(posedge clk) dack_j <= 6'h1d;
    mreq <= 1'b1;
    tick(3);
    chk("mis_oe", {8'h00, drq_oe}, 16'h0008);
    rd(BASE + `HIDR_IDX_STAT, 8'h04, "mis_st");
    @(posedge clk) rst_n <= 1'b0;
    tick(1);
    chk("rst_drq", {8'h00, drq_oe}, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    tick(2);
    chk("rst_irq", irq_oe, 16'h0000);
    chk("rst_drq2", {8'h00, drq_oe}, 16'h0000);
    rd(BASE + `HIDR_IDX_CTRL, 8'h00, "rst_ctrl");
    $display("test dma done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ### hw/hidr_irq_route.sv
// One routed interrupt output: level select, enable and line drivers
`timescale 1ns/1ps
`default_nettype none
module hidr_irq_route
  import hidr_pkg::*;
#(
  parameter int LINES = 16  // Host request lines
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire hidr_level_t       level,
  input  wire logic              enable,
  input  wire logic              request,
  output var  logic [LINES-1:0]  line_out,
  output var  logic [LINES-1:0]  line_oe
);
  // Level numbers reach 15, so fewer lines cannot be served
  if (LINES < 16) begin : g_lines_check
    $error("hidr_irq_route: LINES below 16");
  end

  logic             route_ok;   // Route selected and software enabled
  logic [LINES-1:0] line_hot;   // Selected line
  logic [LINES-1:0] oe_next;
  logic [LINES-1:0] out_next;

  assign route_ok = enable && hidr_irq_ok(level);
  assign line_hot = LINES'(1) << level;
  // Drive both levels while enabled, no wired-OR mode
  assign oe_next  = route_ok ? line_hot : '0;
  assign out_next = (route_ok && request) ? line_hot : '0;

  // Registered drivers; reset leaves the line released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_oe  <= '0;
      line_out <= '0;
    end else begin
      line_oe  <= oe_next;
      line_out <= out_next;
    end
  end
endmodule : hidr_irq_route
`default_nettype wire

// ### hw/hidr_map.svh
// Offsets, field positions and reset values of the host I/O decode block
`ifndef HIDR_MAP_SVH
`define HIDR_MAP_SVH
// Register indices inside the 32-byte window
`define HIDR_IDX_CTRL   5'h00
`define HIDR_IDX_STAT   5'h01
`define HIDR_IDX_CLR    5'h02
`define HIDR_IDX_IEN    5'h03
`define HIDR_IDX_ROUTE  5'h04
`define HIDR_IDX_DMA    5'h05
// Control register bits
`define HIDR_CTRL_BIRQ  0
`define HIDR_CTRL_EIRQ  1
`define HIDR_CTRL_MDMA  2
`define HIDR_CTRL_SDMA  3
// Status, clear and enable bits
`define HIDR_ST_BERR    0
`define HIDR_ST_EIRQ    1
`define HIDR_ST_DMAMIS  2
// Reset values
`define HIDR_CTRL_RST   4'h0
`define HIDR_STAT_RST   3'h0
`define HIDR_IEN_RST    3'h0
`define HIDR_DEF_BASE   5'h1a
`define HIDR_DEF_BIRQ   4'hc
`define HIDR_DEF_EIRQ   4'ha
`define HIDR_DEF_MDMA   3'h6
`define HIDR_DEF_SDMA   3'h3
// Codes for an unused route, and the reserved host page
`define HIDR_IRQ_UNUSED 4'h0
`define HIDR_DMA_UNUSED 3'h4
`define HIDR_LOW_PAGE   2'h0
`endif

// ### hw/hidr_pkg.sv
// Types and shared decode functions of the host I/O decode block
package hidr_pkg;
  typedef logic [3:0] hidr_level_t;   // Host interrupt level number
  typedef logic [2:0] hidr_chan_t;    // Host DMA channel number

  // True for the eleven levels that the board may drive
  function automatic logic hidr_irq_ok(input hidr_level_t lvl);
    case (lvl)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: hidr_irq_ok = 1'b1;
      default: hidr_irq_ok = 1'b0;
    endcase
  endfunction : hidr_irq_ok

  // True for channels 0..3 and 5..7; 4 is the cascade, used as unused
  function automatic logic hidr_chan_ok(input hidr_chan_t ch);
    hidr_chan_ok = (ch != 3'h4);
  endfunction : hidr_chan_ok

  // One-hot line select for a DMA channel
  function automatic logic [7:0] hidr_chan_hot(input hidr_chan_t ch);
    hidr_chan_hot = 8'h01 << ch;
  endfunction : hidr_chan_hot
endpackage : hidr_pkg

// ### hw/hidr_top.sv
// Host I/O window decoder with interrupt and DMA line routing
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hidr_map.svh"
module hidr_top
  import hidr_pkg::*;
#(
  parameter int ADDR_W = 10,  // Host I/O address lines decoded
  parameter int DATA_W = 8    // Register data width
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Host I/O register port
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic [DATA_W-1:0] io_wdata,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  output var  logic [DATA_W-1:0] io_rdata,
  output var  logic              io_hit,
  // Board configuration straps
  input  wire logic [4:0]        base_address_switch_bank,
  input  wire logic [7:0]        interrupt_route_jumpers,
  input  wire logic [5:0]        dma_request_route_jumpers,
  input  wire logic [5:0]        dma_ack_route_jumpers,
  // Board events
  input  wire logic              board_err_evt,
  input  wire logic              ext_bus_irq,
  output var  logic              board_irq,
  // Host interrupt request lines
  output var  logic [15:0]       irq_line_out,
  output var  logic [15:0]       irq_line_oe,
  // Host DMA lines and board-side handshakes
  input  wire logic              master_dma_req,
  input  wire logic              slave_dma_req,
  output var  logic [7:0]        drq_line_out,
  output var  logic [7:0]        drq_line_oe,
  input  wire logic [7:0]        dack_line_in,
  output var  logic              master_dma_ack,
  output var  logic              slave_dma_ack
);
  // Address split is fixed at five index bits and five match bits
  if (ADDR_W != 10) begin : g_addr_check
    $error("hidr_top: ADDR_W must be 10");
  end
  // Read data needs room for the widest register
  if (DATA_W < 8) begin : g_data_check
    $error("hidr_top: DATA_W below 8");
  end

  // Sampled straps; reset value is the factory setting
  logic [4:0]  base_reg;         // Window base bits A9..A5
  hidr_level_t birq_lvl_reg;     // Board interrupt level
  hidr_level_t eirq_lvl_reg;     // External bus interrupt level
  hidr_chan_t  mreq_reg;         // Master request channel
  hidr_chan_t  sreq_reg;         // Slave request channel
  hidr_chan_t  mack_reg;         // Master acknowledge channel
  hidr_chan_t  sack_reg;         // Slave acknowledge channel

  // Software registers
  logic [3:0]  ctrl_reg;         // Interrupt and DMA enables
  logic [3:0]  ctrl_next;
  logic [2:0]  stat_reg;         // Sticky event bits
  logic [2:0]  stat_next;
  logic [2:0]  ien_reg;          // Status interrupt mask
  logic [2:0]  ien_next;
  logic [DATA_W-1:0] rdata_next;

  // Window decode
  logic [4:0]  reg_idx;          // Register index A4..A0
  logic        win_match;        // A9..A5 equal switch setting
  logic        low_page;         // Reserved motherboard page
  logic        wr_hit;
  logic        rd_hit;

  // Event and DMA decode
  logic [2:0]  stat_set;
  logic [2:0]  stat_clr;
  logic        m_pair_ok;        // Master request and ack agree
  logic        s_pair_ok;        // Slave request and ack agree
  logic        m_dma_on;
  logic        s_dma_on;
  logic [7:0]  m_hot;
  logic [7:0]  s_hot;
  logic [7:0]  drq_oe_next;
  logic [7:0]  drq_out_next;

  // Router outputs
  logic [15:0] b_out;
  logic [15:0] b_oe;
  logic [15:0] e_out;
  logic [15:0] e_oe;

  // Track straps every cycle after reset; a switch reads 1 when off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg     <= `HIDR_DEF_BASE;
      birq_lvl_reg <= `HIDR_DEF_BIRQ;
      eirq_lvl_reg <= `HIDR_DEF_EIRQ;
      mreq_reg     <= `HIDR_DEF_MDMA;
      mack_reg     <= `HIDR_DEF_MDMA;
      sreq_reg     <= `HIDR_DEF_SDMA;
      sack_reg     <= `HIDR_DEF_SDMA;
    end else begin
      base_reg     <= base_address_switch_bank;
      birq_lvl_reg <= interrupt_route_jumpers[3:0];
      eirq_lvl_reg <= interrupt_route_jumpers[7:4];
      mreq_reg     <= dma_request_route_jumpers[2:0];
      sreq_reg     <= dma_request_route_jumpers[5:3];
      mack_reg     <= dma_ack_route_jumpers[2:0];
      sack_reg     <= dma_ack_route_jumpers[5:3];
    end
  end

  // Low five lines only pick the register
  assign reg_idx   = io_addr[4:0];
  // Switch 1 meets A5, switch 5 meets A9
  assign win_match = (io_addr[9:5] == base_reg);
  // Never answer in the motherboard page, whatever the switches say
  assign low_page  = (io_addr[9:8] == `HIDR_LOW_PAGE);
  assign io_hit    = win_match && !low_page;
  assign wr_hit    = io_wr && io_hit;
  assign rd_hit    = io_rd && io_hit;

  // Control register; enables only change by software write
  assign ctrl_next = (wr_hit && reg_idx == `HIDR_IDX_CTRL) ? io_wdata[3:0] : ctrl_reg;
  assign ien_next  = (wr_hit && reg_idx == `HIDR_IDX_IEN) ? io_wdata[2:0] : ien_reg;

  // Events; external irq keeps its bit set while high
  assign m_pair_ok = (mreq_reg == mack_reg);
  assign s_pair_ok = (sreq_reg == sack_reg);
  assign stat_set[`HIDR_ST_BERR]   = board_err_evt;
  assign stat_set[`HIDR_ST_EIRQ]   = ext_bus_irq;
  assign stat_set[`HIDR_ST_DMAMIS] = (ctrl_reg[`HIDR_CTRL_MDMA] && !m_pair_ok)
                                   || (ctrl_reg[`HIDR_CTRL_SDMA] && !s_pair_ok);
  assign stat_clr  = (wr_hit && reg_idx == `HIDR_IDX_CLR) ? io_wdata[2:0] : 3'h0;
  // Set beats clear so a same-cycle event is kept
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  // Level interrupt while any enabled status bit is set
  assign board_irq = |(stat_reg & ien_reg);

  // Software registers; reset drops every enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `HIDR_CTRL_RST;
      stat_reg <= `HIDR_STAT_RST;
      ien_reg  <= `HIDR_IEN_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      ien_reg  <= ien_next;
    end
  end

  // Read select; unmapped indices and misses read zero
  assign rdata_next =
      !rd_hit                          ? '0 :
      (reg_idx == `HIDR_IDX_CTRL)      ? DATA_W'(ctrl_reg) :
      (reg_idx == `HIDR_IDX_STAT)      ? DATA_W'(stat_reg) :
      (reg_idx == `HIDR_IDX_IEN)       ? DATA_W'(ien_reg) :
      (reg_idx == `HIDR_IDX_ROUTE)     ? DATA_W'({eirq_lvl_reg, birq_lvl_reg}) :
      (reg_idx == `HIDR_IDX_DMA)       ? DATA_W'({1'b0, sreq_reg, 1'b0, mreq_reg}) :
                                         '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= '0;
    end else begin
      io_rdata <= rdata_next;
    end
  end

  // Board status interrupt on the first output
  hidr_irq_route #(
    .LINES (16)
  ) u_board_irq (
    .clk      (clk),
    .rst_n    (rst_n),
    .level    (birq_lvl_reg),
    .enable   (ctrl_reg[`HIDR_CTRL_BIRQ]),
    .request  (board_irq),
    .line_out (b_out),
    .line_oe  (b_oe)
  );

  // External bus interrupt on the second output
  hidr_irq_route #(
    .LINES (16)
  ) u_ext_irq (
    .clk      (clk),
    .rst_n    (rst_n),
    .level    (eirq_lvl_reg),
    .enable   (ctrl_reg[`HIDR_CTRL_EIRQ]),
    .request  (ext_bus_irq),
    .line_out (e_out),
    .line_oe  (e_oe)
  );

  // Merge the two outputs; each is released unless enabled
  assign irq_line_oe  = b_oe | e_oe;
  assign irq_line_out = (b_out & b_oe) | (e_out & e_oe);

  // A channel runs only when enabled, valid and paired
  assign m_dma_on = ctrl_reg[`HIDR_CTRL_MDMA] && hidr_chan_ok(mreq_reg) && m_pair_ok;
  assign s_dma_on = ctrl_reg[`HIDR_CTRL_SDMA] && hidr_chan_ok(sreq_reg) && s_pair_ok;
  assign m_hot    = m_dma_on ? hidr_chan_hot(mreq_reg) : 8'h00;
  assign s_hot    = s_dma_on ? hidr_chan_hot(sreq_reg) : 8'h00;
  assign drq_oe_next  = m_hot | s_hot;
  assign drq_out_next = (master_dma_req ? m_hot : 8'h00) | (slave_dma_req ? s_hot : 8'h00);

  // Acknowledge only counts on an enabled channel
  assign master_dma_ack = m_dma_on && dack_line_in[mack_reg];
  assign slave_dma_ack  = s_dma_on && dack_line_in[sack_reg];

  // Registered request drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drq_line_oe  <= 8'h00;
      drq_line_out <= 8'h00;
    end else begin
      drq_line_oe  <= drq_oe_next;
      drq_line_out <= drq_out_next;
    end
  end

  // Checks on the decode and routing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  miss_read_zero_a: assert property (
    io_rd && !io_hit |=> io_rdata == '0)
    else $error("read outside window returned data");

  window_match_a: assert property (
    io_hit |-> io_addr[9:5] == base_reg && io_addr[9:8] != 2'h0)
    else $error("window claimed on wrong address");

  stat_read_a: assert property (
    io_rd && io_hit && io_addr[4:0] == `HIDR_IDX_STAT
    |=> io_rdata == DATA_W'($past(stat_reg)))
    else $error("status read returned wrong value");

  switch_track_a: assert property (
    ##1 base_reg == $past(base_address_switch_bank))
    else $error("base switches not followed");

  err_sticky_a: assert property (
    board_err_evt |=> stat_reg[`HIDR_ST_BERR] [*1] ##0 1'b1)
    else $error("board error not latched");

  set_wins_a: assert property (
    ext_bus_irq && wr_hit && reg_idx == `HIDR_IDX_CLR && io_wdata[1]
    |=> stat_reg[`HIDR_ST_EIRQ])
    else $error("clear beat a same-cycle event");

  irq_idle_a: assert property (
    !ctrl_reg[`HIDR_CTRL_BIRQ] && !ctrl_reg[`HIDR_CTRL_EIRQ] |=> irq_line_oe == 16'h0000)
    else $error("interrupt line driven while disabled");

  ext_route_a: assert property (
    ctrl_reg[`HIDR_CTRL_EIRQ] && hidr_irq_ok(eirq_lvl_reg) && ext_bus_irq
    |=> irq_line_out[$past(eirq_lvl_reg)] && irq_line_oe[$past(eirq_lvl_reg)])
    else $error("external interrupt not on its level");

  dma_idle_a: assert property (
    !ctrl_reg[`HIDR_CTRL_MDMA] && !ctrl_reg[`HIDR_CTRL_SDMA] |=> drq_line_oe == 8'h00)
    else $error("DMA request driven while disabled");

  dma_pair_a: assert property (
    !m_pair_ok && mreq_reg != sreq_reg |=> !drq_line_oe[$past(mreq_reg)])
    else $error("DMA driven with mismatched jumpers");

  ack_gate_a: assert property (
    master_dma_ack |-> ctrl_reg[`HIDR_CTRL_MDMA] && m_pair_ok)
    else $error("acknowledge passed on disabled channel");

  // Sticky bit survives until its clear
  err_hold_a: assert property (
    stat_reg[`HIDR_ST_BERR] && !(wr_hit && reg_idx == `HIDR_IDX_CLR && io_wdata[`HIDR_ST_BERR])
    |=> stat_reg[`HIDR_ST_BERR])
    else $error("board error bit lost before clear");

  board_route_a: assert property (
    ctrl_reg[`HIDR_CTRL_BIRQ] && hidr_irq_ok(birq_lvl_reg) && board_irq
    |=> irq_line_out[$past(birq_lvl_reg)] && irq_line_oe[$past(birq_lvl_reg)])
    else $error("board interrupt not on its level");

  drq_route_a: assert property (
    m_dma_on && master_dma_req
    |=> drq_line_out[$past(mreq_reg)] && drq_line_oe[$past(mreq_reg)])
    else $error("master request not on its channel");

  rdata_idle_a: assert property (
    !io_rd |=> io_rdata == '0)
    else $error("read data stood beyond its cycle");

  // Main scenarios
  board_irq_c:  cover property (board_irq ##1 irq_line_out[birq_lvl_reg]);
  ext_irq_c:    cover property (ext_bus_irq && ctrl_reg[`HIDR_CTRL_EIRQ] ##1 |irq_line_out);
  master_drq_c: cover property (master_dma_req && m_dma_on ##1 |drq_line_out);
  read_hit_c:   cover property (rd_hit ##1 io_rdata != '0);
  clr_race_c:   cover property (ext_bus_irq && wr_hit && reg_idx == `HIDR_IDX_CLR);
endmodule : hidr_top
`default_nettype wire
